//--- design/cmdd_top.sv
// Message descriptor list walker with per-channel interrupt masking
//
// Operation
// - Message error mask clear: receive too-long, FCS, alignment, abort raise an interrupt.
// - Message error mask hides too-long, FCS, alignment only with MESSAGE_END_FLAG mask set.
// - MESSAGE_END_FLAG mask clear: end of message interrupts in both directions.
// - Buffer mask clear: underflow, overflow and missing descriptor interrupt.
// - Descriptor is three words: status/buffer, data pointer, next pointer.
// - Descriptor read and checked before any data transfer starts.
// - Finished buffer gets status word written over descriptor's first word.
// - Status holds byte count, end of message, owner returned to host.
// - Host-owned descriptor with no-poll bit clear is re-read periodically until device owns it.
// - Processed buffer goes back to host; never reprocessed without new grant.
// - Receive opening flag without owned descriptor interrupts host.
// - No access beyond the end of a data buffer.
// - Channels serviced independently, each with its own lists.
// - Transmit and receive sections walk separate lists the same way, except in self-servicing mode.
// - Linked buffers processed strictly in list order.
// - Self-servicing mode shares one descriptor between transmit and receive.
// - Owner bit 31: one means device owns, zero means host owns.
// - No-poll bit 30 with host ownership parks until the next activate.
// - Head and next pointers word aligned; address is stored value with two zero bits; data pointer passed on whole.
`timescale 1ns/1ps
module cmdd_top #(
   parameter int POLL_CYCLES = cmdd_pkg::POLL_CYCLES_DEF
) (
   input  wire  logic                             clk,
   input  wire  logic                             sys_rst,
   input  wire  logic                             ce,
   input  wire  logic [cmdd_pkg::REG_AW-1:0]      reg_addr,
   input  wire  logic [31:0]                      reg_wdata,
   input  wire  logic                             reg_wr,
   input  wire  logic                             reg_rd,
   output       logic [31:0]                      reg_rdata,
   output       cmdd_pkg::cmdd_mem_t              mem_cmd,
   input  wire  logic                             mem_ack,
   input  wire  logic [31:0]                      mem_rdata,
   output       cmdd_pkg::cmdd_xfer_t             xfer,
   input  wire  cmdd_pkg::cmdd_done_t             done,
   input  wire  cmdd_pkg::cmdd_event_t            event_in,
   output       cmdd_pkg::cmdd_intr_t             intr_evt,
   output       cmdd_pkg::cmdd_intr_t             intr_eom
);
   import cmdd_pkg::*;

   // Per-channel and per-section context
   logic [CFG_W-1:0]  cfg_r     [NCH];
   logic [29:0]       tx_head_r [NCH];
   logic [29:0]       rx_head_r [NCH];
   cmdd_phase_t       phase_r   [NSEC];
   logic [29:0]       ptr_r     [NSEC];
   logic [BLEN_W-1:0] blen_r    [NSEC];
   logic [BLEN_W-1:0] cnt_r     [NSEC];
   logic              eom_r     [NSEC];
   logic [NSEC-1:0]   act_r;
   cmdd_seq_t         seq_r;
   logic [SEC_W-1:0]  cur_r;
   logic [SEC_W-1:0]  rr_r;
   cmdd_mem_t         mem_r;
   cmdd_xfer_t        xfer_r;
   cmdd_intr_t        intr_evt_r;
   cmdd_intr_t        intr_eom_r;
   logic [31:0]       rdata_r;
   logic [31:0]       poll_cnt_r;
   logic              poll_tick_r;
   logic              pick_ok;
   logic [SEC_W-1:0]  pick_sec;
   logic [SEC_W-1:0]  scan_idx;
   logic              ack_now;
   logic [CH_W-1:0]   reg_ch;
   logic [1:0]        reg_sel;
   logic [31:0]       status_word;
   logic [CFG_W-1:0]  ev_cfg;
   logic              frm_err;
   logic              msg_hit;
   logic              buf_hit;
   logic              onr_hit;

   assign reg_rdata = rdata_r;
   assign mem_cmd   = mem_r;
   assign xfer      = xfer_r;
   assign intr_evt  = intr_evt_r;
   assign intr_eom  = intr_eom_r;
   assign ack_now = mem_r.req & mem_ack;
   assign reg_ch  = reg_addr[REG_AW-1:2];
   assign reg_sel = reg_addr[1:0];
   assign ev_cfg  = cfg_r[event_in.sec[SEC_W-1:1]];
   assign frm_err = event_in.too_long || event_in.fcs_err || event_in.align_err;
   assign msg_hit = (event_in.sec[0] == DIR_RX) &&
                    ((!ev_cfg[CFG_MSK_MSG] && (frm_err || event_in.abort)) ||
                     (!ev_cfg[CFG_MSK_EOM] && frm_err));
   assign buf_hit = !ev_cfg[CFG_MSK_BUFFER_UNDERFLOW_OVERFLOW_EVENT] && event_in.underflow_overflow;
   assign onr_hit = !ev_cfg[CFG_MSK_BUFFER_UNDERFLOW_OVERFLOW_EVENT] && event_in.open_flag && (event_in.sec[0] == DIR_RX) &&
                    (phase_r[event_in.sec] inside {PH_IDLE, PH_POLL, PH_PARK});

   // Round-robin pick so no section starves the shared memory port
   always_comb begin
      pick_ok  = 1'b0;
      pick_sec = '0;
      scan_idx = '0;
      for (int i = NSEC - 1; i >= 0; i--) begin
         scan_idx = rr_r + SEC_W'(i);
         if (phase_r[scan_idx] == PH_FETCH || phase_r[scan_idx] == PH_DONE) begin
            pick_ok  = 1'b1;
            pick_sec = scan_idx;
         end
      end
   end

   // Status word returned to the host, owner bit cleared
   always_comb begin
      status_word = '0;
      status_word[OWNER_BIT] = OWNER_HOST;
      status_word[EOM_BIT] = eom_r[pick_sec];
      status_word[BLEN_W-1:0] = cnt_r[pick_sec];
   end

   // Poll interval timer shared by every waiting section
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         poll_cnt_r  <= '0;
         poll_tick_r <= 1'b0;
      end else if (ce) begin
         poll_tick_r <= 1'b0;
         if (poll_cnt_r == 32'(POLL_CYCLES - 1)) begin
            poll_cnt_r  <= '0;
            poll_tick_r <= 1'b1;
         end else begin
            poll_cnt_r <= poll_cnt_r + 32'h0000_0001;
         end
      end
   end

   // Register writes and activate pulses
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         for (int c = 0; c < NCH; c++) begin
            cfg_r[c]     <= CFG_RESET;
            tx_head_r[c] <= '0;
            rx_head_r[c] <= '0;
         end
         act_r <= '0;
      end else if (ce) begin
         act_r <= '0;
         if (reg_wr) begin
            case (reg_sel)
               REG_CFG: cfg_r[reg_ch] <= reg_wdata[CFG_W-1:0];
               REG_TXHEAD: tx_head_r[reg_ch] <= reg_wdata[31:2];
               REG_RXHEAD: rx_head_r[reg_ch] <= reg_wdata[31:2];
               REG_CMD: begin
                  act_r[{reg_ch, DIR_TX}] <= reg_wdata[CMD_ACT_TX];
                  act_r[{reg_ch, DIR_RX}] <= reg_wdata[CMD_ACT_RX];
               end
               default: ;
            endcase
         end
      end
   end

   // Register reads, data valid only in the cycle after the strobe
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rdata_r <= '0;
      end else if (ce) begin
         rdata_r <= '0;
         if (reg_rd) begin
            case (reg_sel)
               REG_CFG: rdata_r <= {{(32 - CFG_W){1'b0}}, cfg_r[reg_ch]};
               REG_TXHEAD: rdata_r <= {tx_head_r[reg_ch], 2'h0};
               REG_RXHEAD: rdata_r <= {rx_head_r[reg_ch], 2'h0};
               REG_CMD: rdata_r <= {{(32 - 2 * PH_W){1'b0}}, phase_r[{reg_ch, DIR_RX}], phase_r[{reg_ch, DIR_TX}]};
               default: rdata_r <= '0;
            endcase
         end
      end
   end

   // Section phase; activate wins over every other update
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         for (int i = 0; i < NSEC; i++) begin
            phase_r[i] <= PH_IDLE;
         end
      end else if (ce) begin
         for (int i = 0; i < NSEC; i++) begin
            if (poll_tick_r && phase_r[i] == PH_POLL) begin
               phase_r[i] <= PH_FETCH;
            end
            if (ack_now && cur_r == SEC_W'(i)) begin
               case (seq_r)
                  SQ_RD_BUF: begin
                     if (!mem_rdata[OWNER_BIT]) begin
                        phase_r[i] <= mem_rdata[NO_POLL_BIT] ? PH_PARK : PH_POLL;
                     end
                  end
                  SQ_RD_DPTR: phase_r[i] <= PH_BUSY;
                  SQ_RD_NEXT: phase_r[i] <= PH_FETCH;
                  default: ;
               endcase
            end
            if (done.valid && done.sec == SEC_W'(i) && phase_r[i] == PH_BUSY) begin
               phase_r[i] <= PH_DONE;
            end
            if (act_r[i]) begin
               phase_r[i] <= PH_FETCH;
            end
         end
      end
   end

   // Descriptor pointer per section
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         for (int i = 0; i < NSEC; i++) begin
            ptr_r[i] <= '0;
         end
      end else if (ce) begin
         if (ack_now && seq_r == SQ_RD_NEXT) begin
            ptr_r[cur_r] <= mem_rdata[31:2];
         end
         for (int c = 0; c < NCH; c++) begin
            if (act_r[{CH_W'(c), DIR_TX}]) begin
               ptr_r[{CH_W'(c), DIR_TX}] <= tx_head_r[c];
            end
            if (act_r[{CH_W'(c), DIR_RX}]) begin
               // Shared descriptor for loopback diagnostics
               ptr_r[{CH_W'(c), DIR_RX}] <= cfg_r[c][CFG_SELF_SERV] ? tx_head_r[c] : rx_head_r[c];
            end
         end
      end
   end

   // Buffer length captured from an owned descriptor
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         for (int i = 0; i < NSEC; i++) begin
            blen_r[i] <= '0;
         end
      end else if (ce) begin
         if (ack_now && seq_r == SQ_RD_BUF && mem_rdata[OWNER_BIT]) begin
            blen_r[cur_r] <= mem_rdata[BLEN_W-1:0];
         end
      end
   end

   // Completion count, clamped so status never claims bytes past the buffer
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         for (int i = 0; i < NSEC; i++) begin
            cnt_r[i] <= '0;
            eom_r[i] <= 1'b0;
         end
      end else if (ce) begin
         if (done.valid && phase_r[done.sec] == PH_BUSY) begin
            cnt_r[done.sec] <= (done.count > blen_r[done.sec]) ? blen_r[done.sec] : done.count;
            eom_r[done.sec] <= done.message_end_flag;
         end
      end
   end

   // Memory sequencer, one descriptor access at a time
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         seq_r <= SQ_SCAN;
         cur_r <= '0;
         rr_r  <= '0;
         mem_r <= '0;
      end else if (ce) begin
         case (seq_r)
            SQ_SCAN: begin
               if (pick_ok) begin
                  cur_r       <= pick_sec;
                  rr_r        <= pick_sec + SEC_W'(1);
                  mem_r.req   <= 1'b1;
                  mem_r.addr  <= {ptr_r[pick_sec], 2'h0} + DESC_OFS_BUF;
                  if (phase_r[pick_sec] == PH_DONE) begin
                     mem_r.we    <= 1'b1;
                     mem_r.wdata <= status_word;
                     seq_r       <= SQ_WR_STAT;
                  end else begin
                     mem_r.we    <= 1'b0;
                     mem_r.wdata <= '0;
                     seq_r       <= SQ_RD_BUF;
                  end
               end
            end
            SQ_RD_BUF: begin
               if (ack_now) begin
                  if (mem_rdata[OWNER_BIT]) begin
                     mem_r.addr <= {ptr_r[cur_r], 2'h0} + DESC_OFS_DPTR;
                     seq_r      <= SQ_RD_DPTR;
                  end else begin
                     mem_r.req <= 1'b0;
                     seq_r     <= SQ_SCAN;
                  end
               end
            end
            SQ_RD_DPTR, SQ_RD_NEXT: begin
               if (ack_now) begin
                  mem_r.req <= 1'b0;
                  seq_r     <= SQ_SCAN;
               end
            end
            SQ_WR_STAT: begin
               if (ack_now) begin
                  mem_r.we    <= 1'b0;
                  mem_r.wdata <= '0;
                  mem_r.addr  <= {ptr_r[cur_r], 2'h0} + DESC_OFS_NEXT;
                  seq_r       <= SQ_RD_NEXT;
               end
            end
            default: begin
               mem_r <= '0;
               seq_r <= SQ_SCAN;
            end
         endcase
      end
   end

   // Data mover start, bounded to the descriptor's length
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         xfer_r <= '0;
      end else if (ce) begin
         xfer_r.valid <= 1'b0;
         if (ack_now && seq_r == SQ_RD_DPTR) begin
            xfer_r.valid <= 1'b1;
            xfer_r.sec   <= cur_r;
            xfer_r.addr  <= mem_rdata;
            xfer_r.len   <= blen_r[cur_r];
         end
      end
   end

   // Event interrupts after masking
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         intr_evt_r <= '0;
      end else if (ce) begin
         intr_evt_r <= '0;
         if (event_in.valid) begin
            intr_evt_r.valid            <= msg_hit || buf_hit || onr_hit;
            intr_evt_r.sec              <= event_in.sec;
            intr_evt_r.cause[INTR_MSG]  <= msg_hit;
            intr_evt_r.cause[INTR_BUFFER_UNDERFLOW_OVERFLOW_EVENT] <= buf_hit;
            intr_evt_r.cause[INTR_ONR]  <= onr_hit;
         end
      end
   end

   // End of message interrupt, either direction
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         intr_eom_r <= '0;
      end else if (ce) begin
         intr_eom_r <= '0;
         if (done.valid && done.message_end_flag && phase_r[done.sec] == PH_BUSY &&
             !cfg_r[done.sec[SEC_W-1:1]][CFG_MSK_EOM]) begin
            intr_eom_r.valid           <= 1'b1;
            intr_eom_r.sec             <= done.sec;
            intr_eom_r.cause[INTR_EOM] <= 1'b1;
         end
      end
   end

endmodule

//--- design/cmdd_pkg.sv
// Constants, states and carrier types of the message descriptor DMA engine
package cmdd_pkg;

   // Channel and section sizing; a section is one direction of one channel
   localparam int CH_W   = 3;
   localparam int SEC_W  = CH_W + 1;
   localparam int NCH    = 2 ** CH_W;
   localparam int NSEC   = 2 ** SEC_W;
   localparam int REG_AW = CH_W + 2;
   localparam int PH_W   = 3;

   // Section direction, the low bit of a section index
   localparam logic DIR_TX = 1'h0;
   localparam logic DIR_RX = 1'h1;

   // Descriptor word offsets in bytes
   localparam logic [31:0] DESC_OFS_BUF  = 32'h0000_0000;
   localparam logic [31:0] DESC_OFS_DPTR = 32'h0000_0004;
   localparam logic [31:0] DESC_OFS_NEXT = 32'h0000_0008;

   // First descriptor word layout
   localparam int OWNER_BIT   = 31;
   localparam int NO_POLL_BIT = 30;
   localparam int EOM_BIT     = 29;
   localparam int BLEN_W      = 14;
   localparam logic OWNER_HOST = 1'h0;

   // Channel configuration register bits
   localparam int CFG_W          = 5;
   localparam int CFG_MSK_BUFFER_UNDERFLOW_OVERFLOW_EVENT   = 1;
   localparam int CFG_MSK_EOM    = 2;
   localparam int CFG_MSK_MSG    = 3;
   localparam int CFG_SELF_SERV  = 4;
   localparam logic [CFG_W-1:0] CFG_RESET = 5'h0_0;

   // Register index within a channel's group of four
   localparam logic [1:0] REG_CFG    = 2'h0;
   localparam logic [1:0] REG_TXHEAD = 2'h1;
   localparam logic [1:0] REG_RXHEAD = 2'h2;
   localparam logic [1:0] REG_CMD    = 2'h3;

   // Command register bits
   localparam int CMD_ACT_TX = 0;
   localparam int CMD_ACT_RX = 1;

   // Interrupt cause bits
   localparam int INTR_MSG  = 0;
   localparam int INTR_EOM  = 1;
   localparam int INTR_BUFFER_UNDERFLOW_OVERFLOW_EVENT = 2;
   localparam int INTR_ONR  = 3;

   // Owner polling interval in clock cycles
   localparam int POLL_CYCLES_DEF = 1024;

   typedef enum logic [PH_W-1:0] {PH_IDLE, PH_FETCH, PH_POLL, PH_PARK, PH_BUSY, PH_DONE} cmdd_phase_t;
   typedef enum logic [2:0] {SQ_SCAN, SQ_RD_BUF, SQ_RD_DPTR, SQ_WR_STAT, SQ_RD_NEXT} cmdd_seq_t;

   typedef struct packed {
      logic        req;
      logic        we;
      logic [31:0] addr;
      logic [31:0] wdata;
   } cmdd_mem_t;

   typedef struct packed {
      logic              valid;
      logic [SEC_W-1:0]  sec;
      logic [31:0]       addr;
      logic [BLEN_W-1:0] len;
   } cmdd_xfer_t;

   typedef struct packed {
      logic              valid;
      logic [SEC_W-1:0]  sec;
      logic [BLEN_W-1:0] count;
      logic              message_end_flag;
   } cmdd_done_t;

   typedef struct packed {
      logic             valid;
      logic [SEC_W-1:0] sec;
      logic             too_long;
      logic             fcs_err;
      logic             align_err;
      logic             abort;
      logic             underflow_overflow;
      logic             open_flag;
   } cmdd_event_t;

   typedef struct packed {
      logic             valid;
      logic [SEC_W-1:0] sec;
      logic [3:0]       cause;
   } cmdd_intr_t;

endpackage

//--- sim/cmdd_checker.sv
// Port-level assertions for the descriptor engine
`timescale 1ns/1ps
module cmdd_checker #(
   parameter int POLL_CYCLES = cmdd_pkg::POLL_CYCLES_DEF
) (
   input wire logic                      clk,
   input wire logic                      sys_rst,
   input wire logic                      ce,
   input wire logic [cmdd_pkg::REG_AW-1:0] reg_addr,
   input wire logic [31:0]               reg_wdata,
   input wire logic                      reg_wr,
   input wire cmdd_pkg::cmdd_mem_t       mem_cmd,
   input wire logic                      mem_ack,
   input wire logic [31:0]               mem_rdata,
   input wire cmdd_pkg::cmdd_xfer_t      xfer,
   input wire cmdd_pkg::cmdd_done_t      done,
   input wire cmdd_pkg::cmdd_event_t     event_in,
   input wire cmdd_pkg::cmdd_intr_t      intr_evt,
   input wire cmdd_pkg::cmdd_intr_t      intr_eom
);
   import cmdd_pkg::*;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   logic [NCH-1:0] meom_r;
   logic [NCH-1:0] mmsg_r;
   logic [NCH-1:0] mbuf_r;
   logic [31:0]    wr_addr_r;
   // Shadow of the mask bits, written only through the register port
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         meom_r <= '0;
         mmsg_r <= '0;
         mbuf_r <= '0;
      end else if (ce && reg_wr && reg_addr[1:0] == REG_CFG) begin
         meom_r[reg_addr[REG_AW-1:2]] <= reg_wdata[CFG_MSK_EOM];
         mmsg_r[reg_addr[REG_AW-1:2]] <= reg_wdata[CFG_MSK_MSG];
         mbuf_r[reg_addr[REG_AW-1:2]] <= reg_wdata[CFG_MSK_BUFFER_UNDERFLOW_OVERFLOW_EVENT];
      end
   end
   // Base of the last status write
   always_ff @(posedge clk) begin
      if (mem_cmd.req && mem_cmd.we && mem_ack) begin
         wr_addr_r <= mem_cmd.addr;
      end
   end
   property p_align;
      mem_cmd.req |-> mem_cmd.addr[1:0] == 2'h0;
   endproperty
   a_align: assert property (p_align) else $error("memory access not word aligned");
   property p_xfer_src;
      xfer.valid |-> $past(mem_cmd.req && mem_ack && !mem_cmd.we) && xfer.addr == $past(mem_rdata);
   endproperty
   a_xfer_src: assert property (p_xfer_src) else $error("transfer not preceded by pointer read");
   property p_stat_own;
      mem_cmd.req && mem_cmd.we |-> mem_cmd.wdata[OWNER_BIT] == OWNER_HOST;
   endproperty
   a_stat_own: assert property (p_stat_own) else $error("status write keeps device ownership");
   property p_next_rd;
      mem_cmd.req && mem_cmd.we && mem_ack
         |-> ##[1:64] (mem_cmd.req && !mem_cmd.we && mem_cmd.addr == wr_addr_r + DESC_OFS_NEXT);
   endproperty
   a_next_rd: assert property (p_next_rd) else $error("next pointer not read after status");
   property p_eom_src;
      intr_eom.valid |-> $past(done.valid && done.message_end_flag && !meom_r[done.sec[SEC_W-1:1]])
         && intr_eom.sec == $past(done.sec) && intr_eom.cause[INTR_EOM];
   endproperty
   a_eom_src: assert property (p_eom_src) else $error("end of message pulse without cause");
   property p_eom_hide;
      done.valid && meom_r[done.sec[SEC_W-1:1]] |=> !intr_eom.valid;
   endproperty
   a_eom_hide: assert property (p_eom_hide) else $error("masked end of message interrupted");
   property p_abort;
      event_in.valid && event_in.sec[0] == DIR_RX && event_in.abort && !mmsg_r[event_in.sec[SEC_W-1:1]]
         |=> intr_evt.valid && intr_evt.cause[INTR_MSG] && intr_evt.sec == $past(event_in.sec);
   endproperty
   a_abort: assert property (p_abort) else $error("abort not reported");
   property p_msg_hide;
      event_in.valid && !event_in.abort && mmsg_r[event_in.sec[SEC_W-1:1]] && meom_r[event_in.sec[SEC_W-1:1]]
         |=> !(intr_evt.valid && intr_evt.cause[INTR_MSG]);
   endproperty
   a_msg_hide: assert property (p_msg_hide) else $error("masked message error reported");
   property p_buffer_underflow_overflow_event;
      event_in.valid && event_in.underflow_overflow && !mbuf_r[event_in.sec[SEC_W-1:1]]
         |=> intr_evt.valid && intr_evt.cause[INTR_BUFFER_UNDERFLOW_OVERFLOW_EVENT];
   endproperty
   a_buffer_underflow_overflow_event: assert property (p_buffer_underflow_overflow_event) else $error("buffer fault not reported");
   c_xfer: cover property (xfer.valid);
   c_eom: cover property (intr_eom.valid);
   c_msg: cover property (intr_evt.valid && intr_evt.cause[INTR_MSG]);
endmodule

bind cmdd_top cmdd_checker #(.POLL_CYCLES(POLL_CYCLES)) u_chk (
   .clk(clk), .sys_rst(sys_rst), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .mem_cmd(mem_cmd), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .xfer(xfer), .done(done),
   .event_in(event_in), .intr_evt(intr_evt), .intr_eom(intr_eom)
);

//--- sim/cmdd_mem_model.sv
// Shared host memory answering descriptor accesses
`timescale 1ns/1ps
module cmdd_mem_model (
   input  wire logic                clk,
   input  wire logic                slow,
   input  wire cmdd_pkg::cmdd_mem_t mem_cmd,
   output      logic                mem_ack,
   output      logic [31:0]         mem_rdata
);
   import cmdd_pkg::*;
   logic [31:0] mem [0:255];
   int          rd_cnt [0:255];
   logic [1:0]  wait_r;
   logic [31:0] last_r;
   initial begin
      foreach (mem[i]) mem[i] = 32'h0000_0000;
      foreach (rd_cnt[i]) rd_cnt[i] = 0;
      wait_r = 2'h0;
      last_r = 32'h0000_0000;
   end
   // Slow mode stalls three cycles before each access after the first
   assign mem_ack = mem_cmd.req && wait_r == 2'h0;
   // Idle data bus toggles so a stale word never matches
   assign mem_rdata = (mem_ack && !mem_cmd.we) ? mem[mem_cmd.addr[9:2]] : ~last_r;
   always @(posedge clk) begin
      last_r <= mem_rdata;
      if (mem_ack) begin
         wait_r <= slow ? 2'h3 : 2'h0;
         if (mem_cmd.we) begin
            mem[mem_cmd.addr[9:2]] <= mem_cmd.wdata;
         end else begin
            rd_cnt[mem_cmd.addr[9:2]] <= rd_cnt[mem_cmd.addr[9:2]] + 1;
         end
      end else if (mem_cmd.req) begin
         wait_r <= wait_r - 2'h1;
      end
   end
endmodule

//--- sim/cmdd_tb_top.sv
// Self-checking bench for the descriptor engine
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin miscompares++; $display("Error %0t got %h exp %h", $time, g, e); end end
module cmdd_tb_top;
   import cmdd_pkg::*;
   logic              clk;
   logic              sys_rst;
   logic [REG_AW-1:0] reg_addr;
   logic [31:0]       reg_wdata;
   logic              reg_wr;
   logic              reg_rd;
   logic [31:0]       reg_rdata;
   logic [31:0]       rd_v;
   logic              slow;
   logic              mem_ack;
   logic [31:0]       mem_rdata;
   cmdd_mem_t         mem_cmd;
   cmdd_xfer_t        xfer;
   cmdd_xfer_t        xf;
   cmdd_done_t        done;
   cmdd_event_t       event_in;
   cmdd_event_t       ev;
   cmdd_intr_t        intr_evt;
   cmdd_intr_t        intr_eom;
   logic [3:0]        cf;
   logic [1:0]        ex;
   logic              got;
   int                checks;
   int                miscompares;
   int                seed = 32'h3062_4278;

   cmdd_top #(.POLL_CYCLES(8)) dut (.clk(clk), .sys_rst(sys_rst), .ce(1'b1), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_cmd(mem_cmd),
      .mem_ack(mem_ack), .mem_rdata(mem_rdata), .xfer(xfer), .done(done), .event_in(event_in),
      .intr_evt(intr_evt), .intr_eom(intr_eom));
   cmdd_mem_model u_mem (.clk(clk), .slow(slow), .mem_cmd(mem_cmd), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

   task automatic summarize();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic reg_op(input logic wr, input logic [REG_AW-1:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_wr <= wr;
      reg_rd <= !wr;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      #1;
      rd_v = reg_rdata;
   endtask

   task automatic pulse(input cmdd_done_t d, input cmdd_event_t e);
      @(posedge clk);
      done <= d;
      event_in <= e;
      @(posedge clk);
      done <= '0;
      event_in <= '0;
      #1;
   endtask

   task automatic wait_xfer(input int lim);
      got = 1'b0;
      repeat (lim) begin
         @(posedge clk);
         #1;
         if (xfer.valid === 1'b1) begin
            got = 1'b1;
            xf = xfer;
            break;
         end
      end
   endtask

   function automatic logic [31:0] stat_exp(input logic message_end_flag, input int cnt, input int len);
      stat_exp = {2'h0, message_end_flag, 15'h0, 14'(cnt > len ? len : cnt)};
   endfunction

   function automatic logic [1:0] evt_exp(input logic [3:0] c, input cmdd_event_t e);
      logic m;
      logic b;
      m = e.sec[0] & (e.abort & !c[CFG_MSK_MSG] | (e.too_long | e.fcs_err | e.align_err) & !(c[CFG_MSK_MSG] & c[CFG_MSK_EOM]));
      b = !c[CFG_MSK_BUFFER_UNDERFLOW_OVERFLOW_EVENT] & (e.underflow_overflow | e.sec[0] & e.open_flag);
      evt_exp = {b, m};
   endfunction

   // Two linked buffers, wrap back to the first; ends parked on the second
   task automatic run_chain(input int ch, input logic dir, input int w, input logic mk);
      logic [13:0] len [2];
      logic [31:0] dp [2];
      int          n;
      reg_op(1, {3'(ch), REG_CFG}, {29'h0, mk, 2'h0});
      for (int k = 0; k < 2; k++) begin
         len[k] = 14'($unsigned($random(seed)) % 200 + 1);
         dp[k] = $random(seed);
         u_mem.mem[w+3*k] = {1'b1, 1'b0, k[0], 15'h0, len[k]};
         u_mem.mem[w+3*k+1] = dp[k];
         u_mem.mem[w+3*k+2] = 32'(4 * (k ? w : w + 3));
      end
      reg_op(1, {3'(ch), dir ? REG_RXHEAD : REG_TXHEAD}, 32'(4 * w) | 32'h0000_0003);
      reg_op(0, {3'(ch), dir ? REG_RXHEAD : REG_TXHEAD}, 32'h0000_0000);
      `CHK(rd_v, 32'(4 * w))
      reg_op(1, {3'(ch), REG_CMD}, dir ? 32'h0000_0002 : 32'h0000_0001);
      for (int k = 0; k < 3; k++) begin
         wait_xfer(200);
         `CHK({got, xf.sec, xf.addr, xf.len}, {1'b1, 3'(ch), dir, dp[k%2], len[k%2]})
         n = (k == 1) ? len[1] + 7 : len[k%2];
         pulse({1'b1, 3'(ch), dir, 14'(n), k[0]}, '0);
         `CHK(intr_eom.valid, k[0] & !mk)
         repeat (100) if (u_mem.mem[w+3*(k%2)][OWNER_BIT] !== OWNER_HOST) @(posedge clk);
         `CHK(u_mem.mem[w+3*(k%2)] & 32'hA000_3FFF, stat_exp(k[0], n, len[k%2]))
         if (k == 1) begin
            n = u_mem.rd_cnt[w];
            wait_xfer(40);
            `CHK(got, 1'b0)
            `CHK(u_mem.rd_cnt[w] - n > 2, 1'b1)
            u_mem.mem[w+3] = {2'h1, 30'h0};
            u_mem.mem[w] = {1'b1, 17'h0, len[0]};
         end
      end
      repeat (20) @(posedge clk);
      n = u_mem.rd_cnt[w+3];
      reg_op(0, {3'(ch), REG_CMD}, 32'h0000_0000);
      `CHK(dir ? rd_v[5:3] : rd_v[2:0], 3'(PH_PARK))
      repeat (30) @(posedge clk);
      `CHK(u_mem.rd_cnt[w+3], n)
   endtask

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   initial begin
      repeat (20000) @(posedge clk);
      miscompares++;
      summarize();
   end

   initial begin
      sys_rst = 1'b1;
      reg_addr = '0;
      reg_wdata = '0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      slow = 1'b0;
      done = '0;
      event_in = '0;
      repeat (3) @(posedge clk);
      sys_rst <= 1'b0;
      run_chain(1, DIR_TX, 16, 1'b1);
      slow <= 1'b1;
      run_chain(2, DIR_RX, 40, 1'b0);
      // Every mask combination on an idle channel, random event mix
      for (int i = 0; i < 64; i++) begin
         cf = 4'((i / 8) << 1);
         if (i % 8 == 0) begin
            reg_op(1, {3'h7, REG_CFG}, {28'h0, cf});
            reg_op(0, {3'h7, REG_CFG}, 32'h0000_0000);
            `CHK(rd_v, {28'h0, cf})
         end
         ev = 11'($random(seed));
         ev.valid = 1'b1;
         ev.sec = {3'h7, ev.sec[0]};
         pulse('0, ev);
         ex = evt_exp(cf, ev);
         `CHK(intr_evt.valid, |ex)
         if (|ex) `CHK({intr_evt.sec, intr_evt.cause[INTR_MSG], |intr_evt.cause[INTR_ONR:INTR_BUFFER_UNDERFLOW_OVERFLOW_EVENT]}, {ev.sec, ex[0], ex[1]})
      end
      u_mem.mem[80] = {1'b1, 17'h0, 14'h0010};
      u_mem.mem[81] = 32'h0000_1234;
      reg_op(1, {3'h3, REG_TXHEAD}, 32'h0000_0140);
      reg_op(1, {3'h3, REG_CFG}, 32'h0000_0010);
      reg_op(1, {3'h3, REG_CMD}, 32'h0000_0002);
      wait_xfer(200);
      `CHK({got, xf.sec, xf.addr}, {1'b1, 4'h7, 32'h0000_1234})
      summarize();
   end
endmodule
